/* rtl/tfb_bridge.sv */
// task file bridge: host register accesses become ide pio cycles
// assumes a single-cycle host strobe interface on the core clock
//
// Summary of operation
// - master dma strobe lasts count plus one cycles
// - strobe register: 5-bit count, resets 1FH
// - strobe count uses 33.3 ns internal cycles
// - task file access becomes peripheral pio cycle
// - cs and da lines follow accessed register
// - command block: cs1 high, cs0 low, da=addr
// - control block: cs1 low, cs0 high, da 11x
// - task file decoded at 40H, 44H and 48H-4FH
// - 8-bit mode pairs two data bytes
// - low byte first, high byte second
// - other registers transfer on single access
// - task file registers reset to 00H
// - count/reason byte passed unchanged
// - sector register passed, reserved for atapi
// - drive/head register passed unchanged
`timescale 1ns/100ps
`include "tfb_params.svh"
module tfb_bridge
  import tfb_pkg::*;
#(
  parameter int PIO_STROBE_CYC = 30
) (
  // clock and resets
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_bus_reset,
  // host register port
  input  wire logic        i_host_wr,
  input  wire logic        i_host_rd,
  input  wire logic [7:0]  i_host_addr,
  input  wire logic [15:0] i_host_wdata,
  input  wire logic        i_bus8_mode,
  input  wire logic [1:0]  i_dma_mode,
  output logic [15:0]      o_host_rdata,
  output logic             o_host_rvalid,
  output logic             o_host_ready,
  // ide pins
  output logic             o_ide_cs1,
  output logic             o_ide_cs0,
  output logic [2:0]       o_ide_da,
  output logic             o_ide_dior_n,
  output logic             o_ide_diow_n,
  output logic [15:0]      o_ide_data_out,
  output logic             o_ide_data_oe,
  input  wire logic [15:0] i_ide_data_in,
  // master dma strobe
  input  wire logic        i_master_dma_mode_start,
  output logic             o_master_dma_mode_strobe
);
  // ---------------------------------------------------------------
  // timing constants
  // ---------------------------------------------------------------
  // one internal cycle in core cycles, rounded up for a least time
  localparam int INT_CYC = (`INT_CYC_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
  localparam int TW = 16;

  // ---------------------------------------------------------------
  // input synchronisers for the ide data pins
  // ---------------------------------------------------------------
  logic [15:0] ide_in_meta_reg;
  logic [15:0] ide_in_sync_reg;
  always_ff @(posedge i_core_clk) begin
    ide_in_meta_reg <= i_ide_data_in;
    ide_in_sync_reg <= ide_in_meta_reg;
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic        rst_all;
  logic [7:0]  err_feat_reg;
  logic [7:0]  count_reg;
  logic [7:0]  sector_reg;
  logic [7:0]  cyl_lo_reg;
  logic [7:0]  cyl_hi_reg;
  logic [7:0]  drive_reg;
  logic [7:0]  alt_stat_reg;
  logic [7:0]  drv_addr_reg;
  logic [15:0] data_word_reg;
  logic [4:0]  strobe_length_count;
  logic        low_byte_seen_reg;
  logic [7:0]  low_byte_reg;
  logic        pio_done;
  logic        pio_done_rd;
  logic [15:0] pio_rd_word;
  logic [2:0]  pio_rd_reg;

  assign rst_all = !i_rst_n || i_bus_reset;

  // host-side copies of the task file
  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      err_feat_reg <= `TF_RESET;
      count_reg    <= `TF_RESET;
      sector_reg   <= `TF_RESET;
      cyl_lo_reg   <= `TF_RESET;
      cyl_hi_reg   <= `TF_RESET;
      drive_reg    <= `TF_RESET;
      alt_stat_reg <= `TF_RESET;
      drv_addr_reg <= `TF_RESET;
    end else if (i_host_wr && o_host_ready) begin
      unique case (i_host_addr)
        `OFS_ERR_FEAT: err_feat_reg <= i_host_wdata[7:0];
        `OFS_COUNT:    count_reg    <= i_host_wdata[7:0];
        `OFS_SECTOR:   sector_reg   <= i_host_wdata[7:0];
        `OFS_CYL_LO:   cyl_lo_reg   <= i_host_wdata[7:0];
        `OFS_CYL_HI:   cyl_hi_reg   <= i_host_wdata[7:0];
        `OFS_DRIVE:    drive_reg    <= i_host_wdata[7:0];
        `OFS_ALT_STAT: alt_stat_reg <= i_host_wdata[7:0];
        `OFS_DRV_ADDR: drv_addr_reg <= i_host_wdata[7:0];
        default: ;
      endcase
    end else if (pio_done_rd) begin
      // reads of 48H-4DH refresh the local copy with the peripheral's answer
      unique case (pio_rd_reg)
        3'h1: err_feat_reg <= pio_rd_word[7:0];
        3'h2: count_reg    <= pio_rd_word[7:0];
        3'h3: sector_reg   <= pio_rd_word[7:0];
        3'h4: cyl_lo_reg   <= pio_rd_word[7:0];
        3'h5: cyl_hi_reg   <= pio_rd_word[7:0];
        3'h6: drive_reg    <= pio_rd_word[7:0];
        default: ;
      endcase
    end
  end

  // strobe timing register, reserved bits read zero
  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      strobe_length_count <= `STROBE_RESET;
    end else if (i_host_wr && o_host_ready && i_host_addr == `OFS_STROBE) begin
      strobe_length_count <= i_host_wdata[`STROBE_MSB:0];
    end
  end

  // ---------------------------------------------------------------
  // access decode: which accesses launch a pio cycle
  // ---------------------------------------------------------------
  logic        is_data;
  logic        is_tf;
  logic        acc;
  logic        launch;
  logic        cs1_d;
  logic        cs0_d;
  logic [2:0]  da_d;
  logic [15:0] wr_word;

  assign acc     = (i_host_wr || i_host_rd) && o_host_ready;
  assign is_data = (i_host_addr == `OFS_DATA);
  // command block at 48..4D plus command, control block at 4E/4F
  assign is_tf   = is_data || (i_host_addr >= `OFS_ERR_FEAT && i_host_addr <= `OFS_DRV_ADDR) ||
                   (i_host_addr == `OFS_COMMAND);
  // data register needs both halves in 8-bit mode, others go at once
  // reads fetch the word on the low byte, writes send it with the high byte
  assign launch  = acc && is_tf && (!is_data || !i_bus8_mode || (i_host_rd ^ low_byte_seen_reg));
  assign wr_word = (is_data && i_bus8_mode) ? {i_host_wdata[7:0], low_byte_reg} : i_host_wdata;

  // pin pattern from the register being addressed
  always_comb begin
    cs1_d = 1'b1;
    cs0_d = 1'b0;
    da_d  = 3'h0;
    unique case (i_host_addr)
      `OFS_DATA:     da_d = 3'h0;
      `OFS_COMMAND:  da_d = 3'h7;
      `OFS_ALT_STAT: begin
        cs1_d = 1'b0;
        cs0_d = 1'b1;
        da_d  = 3'h6;
      end
      `OFS_DRV_ADDR: begin
        cs1_d = 1'b0;
        cs0_d = 1'b1;
        da_d  = 3'h7;
      end
      default:       da_d = 3'(i_host_addr - `OFS_ERR_FEAT + 8'h01);
    endcase
  end

  // byte pairing: low byte first, sequencer restarts after each write cycle
  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      low_byte_seen_reg <= 1'b0;
      low_byte_reg      <= 8'h00;
    end else if (acc && is_data && i_bus8_mode && !low_byte_seen_reg) begin
      low_byte_seen_reg <= 1'b1;
      low_byte_reg      <= i_host_wdata[7:0];
    end else if (acc && is_data && i_bus8_mode && i_host_rd) begin
      low_byte_seen_reg <= 1'b0;
    end else if (pio_done && !pio_done_rd) begin
      low_byte_seen_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // request fifo: {rd, cs1, cs0, da, word}
  // ---------------------------------------------------------------
  localparam int RQW = 1 + 1 + 1 + 3 + 16;
  logic           rq_in_ready;
  logic           rq_valid;
  logic [RQW-1:0] rq_data;
  logic           rq_take;

  tfb_fifo #(.WIDTH(RQW), .DEPTH(`FIFO_DEPTH)) u_req_fifo (
    .i_core_clk (i_core_clk),
    .i_rst_n    (!rst_all),
    .i_in_valid (launch),
    .i_in_data  ({i_host_rd, cs1_d, cs0_d, da_d, wr_word}),
    .o_in_ready (rq_in_ready),
    .o_out_valid(rq_valid),
    .o_out_data (rq_data),
    .i_out_ready(rq_take)
  );

  // ---------------------------------------------------------------
  // pio sequencer
  // ---------------------------------------------------------------
  pio_state_t  pio_state_reg;
  logic [TW-1:0] pio_cnt_reg;
  logic        cur_rd_reg;
  logic        rd_pending_reg;

  assign rq_take     = (pio_state_reg == PIO_IDLE) && rq_valid;
  assign pio_done    = (pio_state_reg == PIO_DONE);
  assign pio_done_rd = pio_done && cur_rd_reg;
  assign pio_rd_word = ide_in_sync_reg;
  assign pio_rd_reg  = o_ide_cs1 ? o_ide_da : 3'h7; // control block must not land in the drive/head copy

  // state and counters for one pio cycle
  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      pio_state_reg  <= PIO_IDLE;
      pio_cnt_reg    <= '0;
      cur_rd_reg     <= 1'b0;
      o_ide_cs1      <= 1'b1;
      o_ide_cs0      <= 1'b1;
      o_ide_da       <= 3'h0;
      o_ide_dior_n   <= 1'b1;
      o_ide_diow_n   <= 1'b1;
      o_ide_data_out <= 16'h0000;
      o_ide_data_oe  <= 1'b0;
    end else begin
      unique case (pio_state_reg)
        PIO_IDLE: if (rq_valid) begin
          {cur_rd_reg, o_ide_cs1, o_ide_cs0, o_ide_da, o_ide_data_out} <= rq_data;
          o_ide_data_oe <= !rq_data[RQW-1];
          pio_cnt_reg   <= TW'(PIO_STROBE_CYC);
          pio_state_reg <= PIO_SETUP;
        end
        PIO_SETUP: begin
          o_ide_dior_n  <= !cur_rd_reg;
          o_ide_diow_n  <= cur_rd_reg;
          pio_state_reg <= PIO_STROBE;
        end
        PIO_STROBE: if (pio_cnt_reg == '0) begin
          o_ide_dior_n  <= 1'b1;
          o_ide_diow_n  <= 1'b1;
          pio_state_reg <= PIO_DONE;
        end else begin
          pio_cnt_reg <= pio_cnt_reg - 1'b1;
        end
        PIO_DONE: begin
          o_ide_data_oe <= 1'b0;
          o_ide_cs1     <= 1'b1;
          o_ide_cs0     <= 1'b1;
          pio_state_reg <= PIO_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // host answers
  // ---------------------------------------------------------------
  // reads of registers without pio answer at once; pio reads wait
  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      o_host_rdata   <= 16'h0000;
      o_host_rvalid  <= 1'b0;
      o_host_ready   <= 1'b0;
      rd_pending_reg <= 1'b0;
      data_word_reg  <= 16'h0000;
    end else begin
      // ready drops while a read is open or the fifo is full
      o_host_ready  <= rq_in_ready && !rd_pending_reg && !(i_host_rd && o_host_ready && launch);
      o_host_rvalid <= 1'b0;
      if (i_host_wr && o_host_ready && is_data && launch) begin
        data_word_reg <= wr_word;
      end
      if (pio_done_rd && rd_pending_reg) begin
        rd_pending_reg <= 1'b0;
        o_host_rvalid  <= 1'b1;
        if (pio_rd_reg == 3'h0) begin
          data_word_reg <= pio_rd_word;
          o_host_rdata  <= i_bus8_mode ? {8'h00, pio_rd_word[7:0]} : pio_rd_word;
        end else begin
          o_host_rdata <= {8'h00, pio_rd_word[7:0]};
        end
      end else if (i_host_rd && o_host_ready) begin
        if (launch) begin
          rd_pending_reg <= 1'b1;
        end else begin
          o_host_rvalid <= 1'b1;
          unique case (i_host_addr)
            `OFS_DATA:   o_host_rdata <= {8'h00, data_word_reg[15:8]};
            `OFS_STROBE: o_host_rdata <= {11'h000, strobe_length_count};
            default:     o_host_rdata <= 16'h0000;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // master dma strobe length
  // ---------------------------------------------------------------
  logic          master_dma_mode_active;
  logic [TW-1:0] strobe_cyc;
  assign strobe_cyc = TW'((32'(strobe_length_count) + 32'd1) * INT_CYC);

  tfb_strobe_timer #(.CW(TW)) u_strobe (
    .i_core_clk(i_core_clk),
    .i_rst_n   (!rst_all),
    .i_start   (i_master_dma_mode_start && i_dma_mode == `MODE_MASTER_DMA_MODE && !master_dma_mode_active),
    .i_cycles  (strobe_cyc),
    .o_active  (master_dma_mode_active)
  );

  // registered copy of the strobe
  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      o_master_dma_mode_strobe <= 1'b0;
    end else begin
      o_master_dma_mode_strobe <= master_dma_mode_active;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_strobe_reset_val: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $past(i_bus_reset) |-> strobe_length_count == 5'h1F) else $error("strobe count not reset");
  a_ctrl_block_pins: assert property (@(posedge i_core_clk) disable iff (rst_all)
    (pio_state_reg == PIO_STROBE && !o_ide_cs1) |-> (o_ide_cs0 && o_ide_da[2:1] == 2'b11))
    else $error("control block pins wrong");
  a_cmd_block_pins: assert property (@(posedge i_core_clk) disable iff (rst_all)
    (pio_state_reg == PIO_STROBE && o_ide_cs1) |-> !o_ide_cs0) else $error("command block pins wrong");
  a_pair_no_launch: assert property (@(posedge i_core_clk) disable iff (rst_all)
    (acc && i_host_wr && is_data && i_bus8_mode && !low_byte_seen_reg) |-> !launch)
    else $error("first data byte launched pio");
  a_single_access: assert property (@(posedge i_core_clk) disable iff (rst_all)
    (acc && is_tf && !is_data) |-> launch) else $error("task file access not forwarded");
  a_pair_restart: assert property (@(posedge i_core_clk) disable iff (rst_all)
    (pio_done && !pio_done_rd && !(acc && is_data && i_bus8_mode)) |=> !low_byte_seen_reg)
    else $error("pairing not restarted");
  a_pio_strobe: assert property (@(posedge i_core_clk) disable iff (rst_all)
    rq_take |-> ##2 (!o_ide_dior_n || !o_ide_diow_n)) else $error("pio strobe missing");
  a_master_dma_mode_len: assert property (@(posedge i_core_clk) disable iff (rst_all)
    $rose(master_dma_mode_active) |-> master_dma_mode_active [*8]) else $error("master_dma_mode strobe too short");
endmodule // tfb_bridge

/* rtl/tfb_params.svh */
// constants for the task file bridge: offsets, reset values, timing
// assumes nothing; included by bare name from the rtl files
`ifndef TFB_PARAMS_SVH
`define TFB_PARAMS_SVH
`define OFS_DATA       8'h40
`define OFS_ERR_FEAT   8'h48
`define OFS_COUNT      8'h49
`define OFS_SECTOR     8'h4A
`define OFS_CYL_LO     8'h4B
`define OFS_CYL_HI     8'h4C
`define OFS_DRIVE      8'h4D
`define OFS_COMMAND    8'h44
`define OFS_ALT_STAT   8'h4E
`define OFS_DRV_ADDR   8'h4F
`define OFS_STROBE     8'h60
`define TF_RESET       8'h00
`define STROBE_RESET   5'h1F
`define STROBE_MSB     4
`define MODE_MASTER_DMA_MODE      2'h3
`define CMD_READ_VAL   8'hFF
`define CLK_PERIOD_PS  4000
`define INT_CYC_PS     33300
`define FIFO_DEPTH     8
`endif

/* rtl/tfb_pkg.sv */
// types shared by the task file bridge files
// assumes the params header sits beside it
package tfb_pkg;
  typedef enum logic [3:0] {
    PIO_IDLE   = 4'b0001,
    PIO_SETUP  = 4'b0010,
    PIO_STROBE = 4'b0100,
    PIO_DONE   = 4'b1000
  } pio_state_t;
endpackage

/* rtl/tfb_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module tfb_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data  = mem_reg[rd_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // storage has no reset, only pointers need one
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tfb_fifo

/* rtl/tfb_strobe_timer.sv */
// counts one strobe of n+1 internal cycles in core clock cycles
// assumes a start pulse only while idle
`timescale 1ns/100ps
module tfb_strobe_timer #(
  parameter int CW = 16
) (
  // clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_n,
  // control
  input  wire logic          i_start,
  input  wire logic [CW-1:0] i_cycles,
  output logic               o_active
);
  logic [CW-1:0] left_reg;

  // strobe stays on while cycles remain
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      left_reg <= '0;
    end else if (i_start) begin
      left_reg <= i_cycles;
    end else if (left_reg != '0) begin
      left_reg <= left_reg - 1'b1;
    end
  end
  assign o_active = (left_reg != '0);
endmodule // tfb_strobe_timer

/* dv/ide_drive_model.sv */
// ------------------------------------------------------------
// behavioural ide drive seen across the pio pins
// ------------------------------------------------------------
// assumes registered active-low strobes on the core clock
`timescale 1ns/100ps
module ide_drive_model (
  // clock
  input  wire logic        i_core_clk,
  // ide pins from the bridge
  input  wire logic        i_cs1,
  input  wire logic        i_cs0,
  input  wire logic [2:0]  i_da,
  input  wire logic        i_dior_n,
  input  wire logic        i_diow_n,
  input  wire logic [15:0] i_data,
  input  wire logic        i_data_oe,
  // data back to the bridge
  output logic [15:0]      o_data,
  // observation of the last write
  output logic [4:0]       o_last_sel,
  output logic [15:0]      o_last_wdata,
  output int               o_wr_count
);
  logic [15:0] regs_q [32];
  logic [15:0] last_drv;
  logic        diow_prev;
  wire  [4:0]  sel = {i_cs1, i_cs0, i_da};

  initial begin
    foreach (regs_q[k]) regs_q[k] = 16'h0000;
    last_drv     = 16'h0000;
    diow_prev    = 1'b1;
    o_last_sel   = 5'h00;
    o_last_wdata = 16'h0000;
    o_wr_count   = 0;
  end

  // released bus shows the inverse of its last value, never a stale copy
  assign o_data = (!i_dior_n) ? regs_q[sel] : ~last_drv;

  // a write lands on the rising edge of the write strobe
  always @(posedge i_core_clk) begin
    if (!i_dior_n)
      last_drv <= regs_q[sel];
    if (!diow_prev && i_diow_n && i_data_oe) begin
      regs_q[sel]  <= i_data;
      o_last_sel   <= sel;
      o_last_wdata <= i_data;
      o_wr_count   <= o_wr_count + 1;
    end
    diow_prev <= i_diow_n;
  end
endmodule // ide_drive_model

/* dv/ide_taskfile_pio_bridge_test.sv */
// ------------------------------------------------------------
// self-checking bench for the task file bridge
// ------------------------------------------------------------
// assumes the bridge and fifo rtl plus the drive model are compiled first
`timescale 1ns/100ps
`include "tfb_params.svh"
module ide_taskfile_pio_bridge_test;
  localparam int STB = 4;
  logic        i_core_clk, i_rst_n, i_bus_reset, i_host_wr, i_host_rd, i_bus8_mode, i_master_dma_mode_start;
  logic [7:0]  i_host_addr;
  logic [15:0] i_host_wdata, o_host_rdata, o_ide_data_out, ide_in;
  logic [1:0]  i_dma_mode;
  logic        o_host_rvalid, o_host_ready, o_ide_cs1, o_ide_cs0, o_ide_dior_n, o_ide_diow_n;
  logic        o_ide_data_oe, o_master_dma_mode_strobe;
  logic [2:0]  o_ide_da;
  logic [4:0]  last_sel;
  logic [15:0] last_wdata, rd_val;
  int          wr_count, num_errors, check_count, cycles;

  tfb_bridge #(.PIO_STROBE_CYC(STB)) uut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_bus_reset(i_bus_reset),
    .i_host_wr(i_host_wr), .i_host_rd(i_host_rd), .i_host_addr(i_host_addr),
    .i_host_wdata(i_host_wdata), .i_bus8_mode(i_bus8_mode), .i_dma_mode(i_dma_mode),
    .o_host_rdata(o_host_rdata), .o_host_rvalid(o_host_rvalid), .o_host_ready(o_host_ready),
    .o_ide_cs1(o_ide_cs1), .o_ide_cs0(o_ide_cs0), .o_ide_da(o_ide_da),
    .o_ide_dior_n(o_ide_dior_n), .o_ide_diow_n(o_ide_diow_n), .o_ide_data_out(o_ide_data_out),
    .o_ide_data_oe(o_ide_data_oe), .i_ide_data_in(ide_in),
    .i_master_dma_mode_start(i_master_dma_mode_start), .o_master_dma_mode_strobe(o_master_dma_mode_strobe));

  ide_drive_model drive (
    .i_core_clk(i_core_clk), .i_cs1(o_ide_cs1), .i_cs0(o_ide_cs0), .i_da(o_ide_da),
    .i_dior_n(o_ide_dior_n), .i_diow_n(o_ide_diow_n), .i_data(o_ide_data_out),
    .i_data_oe(o_ide_data_oe), .o_data(ide_in), .o_last_sel(last_sel),
    .o_last_wdata(last_wdata), .o_wr_count(wr_count));

  // ------------------------------------------------------------
  // clock, hang guard, verdict
  // ------------------------------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  // ceiling sits well above the fewer than two thousand cycles the scenarios need
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ------------------------------------------------------------
  // host bus tasks, driven on the falling edge
  // ------------------------------------------------------------
  task automatic wait_ready();
    int n;
    n = 0;
    while (o_host_ready !== 1'b1 && n < 200) begin
      @(negedge i_core_clk);
      n++;
    end
    if (n == 200)
      check("host ready", 16'h0000, 16'h0001);
  endtask

  task automatic host_write(input logic [7:0] a, input logic [15:0] d);
    wait_ready();
    i_host_wr    = 1'b1;
    i_host_addr  = a;
    i_host_wdata = d;
    @(negedge i_core_clk);
    i_host_wr    = 1'b0;
    // one idle edge so a following call never re-raises the strobe in the same step
    @(negedge i_core_clk);
  endtask

  task automatic host_read(input logic [7:0] a, output logic [15:0] d);
    int n;
    wait_ready();
    i_host_rd   = 1'b1;
    i_host_addr = a;
    @(negedge i_core_clk);
    i_host_rd   = 1'b0;
    n = 0;
    while (o_host_rvalid !== 1'b1 && n < 200) begin
      @(negedge i_core_clk);
      n++;
    end
    d = o_host_rdata;
    if (n == 200)
      check("read answer", 16'h0000, 16'h0001);
    @(negedge i_core_clk);
  endtask

  // waits for the drive to see a given number of writes
  task automatic wait_writes(input int want);
    int n;
    n = 0;
    while (wr_count < want && n < 300) begin
      @(negedge i_core_clk);
      n++;
    end
    if (n == 300)
      check("drive write seen", 16'h0000, 16'h0001);
    repeat (3) @(negedge i_core_clk);
  endtask

  task automatic apply_reset(input bit bus);
    @(negedge i_core_clk);
    if (bus) i_bus_reset = 1'b1;
    else     i_rst_n     = 1'b0;
    repeat (16) @(negedge i_core_clk);
    i_bus_reset = 1'b0;
    i_rst_n     = 1'b1;
    repeat (2) @(negedge i_core_clk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_reset_values();
    host_read(`OFS_STROBE, rd_val);
    check("strobe reset", {11'h000, rd_val[4:0]}, 16'h001F);
    host_read(`OFS_ERR_FEAT, rd_val);
    check("feature reset", rd_val & 16'h00FF, 16'h0000);
  endtask

  // each command block register goes out on one access, each awaited at the drive before the next, command last
  task automatic test_task_file_writes();
    logic [7:0] offs [7];
    int base;
    offs = '{`OFS_ERR_FEAT, `OFS_COUNT, `OFS_SECTOR, `OFS_CYL_LO, `OFS_CYL_HI, `OFS_DRIVE, `OFS_COMMAND};
    for (int k = 0; k < 7; k++) begin
      base = wr_count;
      host_write(offs[k], {8'h00, 8'hA1 + 8'(k)});
      wait_writes(base + 1);
      check("tf sel", {11'h000, last_sel}, {11'h000, 2'b10, 3'(k + 1)});
      check("tf data", last_wdata & 16'h00FF, {8'h00, 8'hA1 + 8'(k)});
    end
    host_read(`OFS_COUNT, rd_val);
    check("count readback", rd_val & 16'h00FF, 16'h00A2);
    host_read(`OFS_DRIVE, rd_val);
    check("drive readback", rd_val & 16'h00FF, 16'h00A6);
  endtask

  task automatic test_control_block();
    int base;
    base = wr_count;
    host_write(`OFS_ALT_STAT, 16'h0055);
    wait_writes(base + 1);
    check("alt sel", {11'h000, last_sel}, 16'h000E);
    host_write(`OFS_DRV_ADDR, 16'h0066);
    wait_writes(base + 2);
    check("drv addr sel", {11'h000, last_sel}, 16'h000F);
  endtask

  task automatic test_data16();
    int base;
    base = wr_count;
    host_write(`OFS_DATA, 16'hBEEF);
    wait_writes(base + 1);
    check("data16 sel", {11'h000, last_sel}, 16'h0010);
    check("data16 word", last_wdata, 16'hBEEF);
    host_read(`OFS_SECTOR, rd_val);
    check("sector readback", rd_val & 16'h00FF, 16'h00A3);
  endtask

  // low byte alone launches nothing; a bus reset drops a half pair
  task automatic test_byte_pairing();
    int base;
    i_bus8_mode = 1'b1;
    base = wr_count;
    host_write(`OFS_DATA, 16'h0077);
    repeat (STB + 12) @(negedge i_core_clk);
    check("no pio on first byte", 16'(wr_count), 16'(base));
    apply_reset(1'b1);
    host_write(`OFS_DATA, 16'h0034);
    host_write(`OFS_DATA, 16'h0012);
    wait_writes(base + 1);
    check("paired word", last_wdata, 16'h1234);
    host_write(`OFS_DATA, 16'h00CD);
    host_write(`OFS_DATA, 16'h00AB);
    wait_writes(base + 2);
    check("second pair", last_wdata, 16'hABCD);
    // byte reads hand out the drive's word low byte first
    host_read(`OFS_DATA, rd_val);
    check("read low byte", rd_val, 16'h00CD);
    host_read(`OFS_DATA, rd_val);
    check("read high byte", rd_val, 16'h00AB);
    i_bus8_mode = 1'b0;
  endtask

  // strobe lasts (n+1) internal cycles of 9 core cycles each
  task automatic strobe_len(input logic [1:0] mode, input logic [4:0] n, input int exp);
    int hi;
    host_write(`OFS_STROBE, {11'h7FF, n});
    i_dma_mode = mode;
    repeat (2) @(negedge i_core_clk);
    i_master_dma_mode_start = 1'b1;
    @(negedge i_core_clk);
    i_master_dma_mode_start = 1'b0;
    hi = 0;
    for (int k = 0; k < 400; k++) begin
      if (o_master_dma_mode_strobe === 1'b1) hi++;
      @(negedge i_core_clk);
    end
    check("strobe length", 16'(hi), 16'(exp));
  endtask

  task automatic test_strobe();
    strobe_len(2'h3, 5'h02, 27);
    strobe_len(2'h3, 5'h00, 9);
    strobe_len(2'h2, 5'h02, 0);
    host_read(`OFS_STROBE, rd_val);
    check("strobe count field", {11'h000, rd_val[4:0]}, 16'h0002);
    apply_reset(1'b1);
    host_read(`OFS_STROBE, rd_val);
    check("strobe bus reset", {11'h000, rd_val[4:0]}, 16'h001F);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    num_errors   = 0;
    check_count  = 0;
    cycles       = 0;
    i_rst_n      = 1'b0;
    i_bus_reset  = 1'b0;
    i_host_wr    = 1'b0;
    i_host_rd    = 1'b0;
    i_host_addr  = 8'h00;
    i_host_wdata = 16'h0000;
    i_bus8_mode  = 1'b0;
    i_dma_mode   = 2'h0;
    i_master_dma_mode_start = 1'b0;
    repeat (16) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_core_clk);
    test_reset_values();
    test_task_file_writes();
    test_control_block();
    test_data16();
    test_byte_pairing();
    test_strobe();
    give_verdict();
  end
endmodule // ide_taskfile_pio_bridge_test
